// File: hdl/rf_cfg_pkg.sv
// Behaviour
// - Low two transmit bits set extra wait
// - Response wait adds seven bit periods
// - Parity off stops parity generate and check
// - Parity off passes parity bit as data
// - Reserved addresses only hold reset values
// - Speed bits 7..5 are coarse factor
// - Speed bits 4..0 are fine factor
// - Speed register resets to EBh
// - CRC high at 21h, low at 22h
// - CRC bytes valid only with done flag
// - Both CRC bytes reset to FFh
// - Modulation pulse lasts setting plus one carriers
package rf_cfg_pkg;
    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_TX_PARAM = 6'h1C;
    localparam logic [5:0] OFS_RX_PARAM = 6'h1D;
    localparam logic [5:0] OFS_RSVD_1E = 6'h1E;
    localparam logic [5:0] OFS_UART_SPEED = 6'h1F;
    localparam logic [5:0] OFS_RSVD_20 = 6'h20;
    localparam logic [5:0] OFS_CRC_HIGH = 6'h21;
    localparam logic [5:0] OFS_CRC_LOW = 6'h22;
    localparam logic [5:0] OFS_RSVD_23 = 6'h23;
    localparam logic [5:0] OFS_MOD_WIDTH = 6'h24;
    localparam logic [5:0] OFS_RSVD_25 = 6'h25;
    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_TX_PARAM = 8'h62;
    localparam logic [7:0] RST_RX_PARAM = 8'h00;
    localparam logic [7:0] RST_RSVD_1E = 8'h00;
    localparam logic [7:0] RST_UART_SPEED = 8'hEB;
    localparam logic [7:0] RST_RSVD_20 = 8'h00;
    localparam logic [7:0] RST_CRC_BYTE = 8'hFF;
    localparam logic [7:0] RST_RSVD_23 = 8'h88;
    localparam logic [7:0] RST_MOD_WIDTH = 8'h26;
    localparam logic [7:0] RST_RSVD_25 = 8'h87;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int TXW_LSB = 0;
    localparam int TXW_W = 2;
    localparam int PAR_OFF_BIT = 4;
    localparam int COARSE_LSB = 5;
    localparam int COARSE_W = 3;
    localparam int FINE_LSB = 0;
    localparam int FINE_W = 5;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam logic [3:0] RESP_WAIT_BASE = 4'h7;
    localparam int CLK_HZ = 10_000_000;
    localparam int BIT_RATE_HZ = 106_000;
    localparam int BIT_DIV_CYC = CLK_HZ / BIT_RATE_HZ;
    localparam int CARRIER_DIV_CYC = 1;
endpackage

// File: hdl/mod_pulse_if.sv
`timescale 1ns/1ps
interface mod_pulse_if;
    logic [7:0] width;
    logic start;
    logic pulse;
    modport ctrl (output width, output start, input pulse);
    modport gen (input width, input start, output pulse);
endinterface

// File: hdl/miller_pulse_gen.sv
`timescale 1ns/1ps
module miller_pulse_gen #(
    parameter int CARRIER_DIV = rf_cfg_pkg::CARRIER_DIV_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    mod_pulse_if.gen mp
);
    if (CARRIER_DIV < 1 || CARRIER_DIV > 256) begin : g_bad_div
        $error("CARRIER_DIV must lie in 1..256");
    end

    localparam logic [7:0] DIV_LAST = 8'(CARRIER_DIV - 1);

    typedef struct packed {
        logic [7:0] div;
        logic [7:0] cnt;
        logic active;
    } gen_state_t;

    gen_state_t st_r;
    gen_state_t st_nxt;

    // ---------------------------------------------------------------
    // Pulse timing
    // ---------------------------------------------------------------
    // The carrier divider restarts with each pulse so that the first
    // carrier period is a whole one and the width is exact.
    always_comb begin
        st_nxt = st_r;
        if (st_r.active) begin
            if (st_r.div == 8'h00) begin
                st_nxt.div = DIV_LAST;
                if (st_r.cnt == 8'h00) begin
                    st_nxt.active = 1'b0;
                end else begin
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end
            end else begin
                st_nxt.div = st_r.div - 8'h01;
            end
        end else if (mp.start) begin
            st_nxt.active = 1'b1;
            st_nxt.cnt = mp.width;
            st_nxt.div = DIV_LAST;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mp.pulse = st_r.active;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    logic [15:0] hi_len_r;
    logic [15:0] want_len_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hi_len_r <= 16'h0000;
            want_len_r <= 16'h0000;
        end else begin
            if (mp.start && !st_r.active) begin
                want_len_r <= 16'((mp.width + 16'h0001) * CARRIER_DIV);
            end
            hi_len_r <= st_r.active ? hi_len_r + 16'h0001 : 16'h0000;
        end
    end

    AST_PULSE_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(st_r.active) |-> hi_len_r == want_len_r)
        else $error("Modulation pulse length differs from setting plus one");
endmodule

// File: hdl/rf_protocol_config_regs.sv
`timescale 1ns/1ps
module rf_protocol_config_regs #(
    parameter int BIT_DIV = rf_cfg_pkg::BIT_DIV_CYC,
    parameter int CARRIER_DIV = rf_cfg_pkg::CARRIER_DIV_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic tx_done,
    output logic response_wait_busy,
    output logic response_wait_done,
    output logic [1:0] added_response_wait,
    output logic tx_parity_gen,
    output logic rx_parity_check,
    output logic rx_parity_as_data,
    output logic [2:0] baud_coarse_factor,
    output logic [4:0] baud_fine_factor,
    input wire logic crc_load,
    input wire logic [15:0] crc_value,
    input wire logic mod_start,
    output logic mod_pulse
);
    if (BIT_DIV < 1 || BIT_DIV > 256) begin : g_bad_bit_div
        $error("BIT_DIV must lie in 1..256");
    end

    localparam logic [7:0] BIT_LAST = 8'(BIT_DIV - 1);

    typedef struct packed {
        logic [1:0] tx_wait;
        logic par_off;
        logic [7:0] speed;
        logic [7:0] crc_high;
        logic [7:0] crc_low;
        logic [7:0] mod_width;
        logic [7:0] rdata;
        logic [7:0] bit_div;
        logic [3:0] wait_cnt;
        logic waiting;
        logic wait_done;
    } cfg_state_t;

    cfg_state_t st_r;
    cfg_state_t st_nxt;
    logic [7:0] rd_val;
    logic bit_tick;

    // ---------------------------------------------------------------
    // Read decode
    // ---------------------------------------------------------------
    // Reserved bits and registers are not stored: they read back as
    // constants, which also makes them immune to writes.
    always_comb begin
        rd_val = 8'h00;
        case (reg_addr)
            rf_cfg_pkg::OFS_TX_PARAM: begin
                rd_val = rf_cfg_pkg::RST_TX_PARAM;
                rd_val[rf_cfg_pkg::TXW_LSB +: rf_cfg_pkg::TXW_W] = st_r.tx_wait;
            end
            rf_cfg_pkg::OFS_RX_PARAM: begin
                rd_val = rf_cfg_pkg::RST_RX_PARAM;
                rd_val[rf_cfg_pkg::PAR_OFF_BIT] = st_r.par_off;
            end
            rf_cfg_pkg::OFS_RSVD_1E: begin
                rd_val = rf_cfg_pkg::RST_RSVD_1E;
            end
            rf_cfg_pkg::OFS_UART_SPEED: begin
                rd_val = st_r.speed;
            end
            rf_cfg_pkg::OFS_RSVD_20: begin
                rd_val = rf_cfg_pkg::RST_RSVD_20;
            end
            rf_cfg_pkg::OFS_CRC_HIGH: begin
                rd_val = st_r.crc_high;
            end
            rf_cfg_pkg::OFS_CRC_LOW: begin
                rd_val = st_r.crc_low;
            end
            rf_cfg_pkg::OFS_RSVD_23: begin
                rd_val = rf_cfg_pkg::RST_RSVD_23;
            end
            rf_cfg_pkg::OFS_MOD_WIDTH: begin
                rd_val = st_r.mod_width;
            end
            rf_cfg_pkg::OFS_RSVD_25: begin
                rd_val = rf_cfg_pkg::RST_RSVD_25;
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
    end

    assign bit_tick = (st_r.bit_div == 8'h00);

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = reg_rd ? rd_val : 8'h00;
        st_nxt.wait_done = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                rf_cfg_pkg::OFS_TX_PARAM: begin
                    st_nxt.tx_wait =
                        reg_wdata[rf_cfg_pkg::TXW_LSB +: rf_cfg_pkg::TXW_W];
                end
                rf_cfg_pkg::OFS_RX_PARAM: begin
                    st_nxt.par_off = reg_wdata[rf_cfg_pkg::PAR_OFF_BIT];
                end
                rf_cfg_pkg::OFS_UART_SPEED: begin
                    st_nxt.speed = reg_wdata;
                end
                rf_cfg_pkg::OFS_MOD_WIDTH: begin
                    st_nxt.mod_width = reg_wdata;
                end
                default: begin
                    st_nxt.speed = st_r.speed;
                end
            endcase
        end
        // The result only moves when the engine finishes, so the bytes
        // stay steady for as long as the done flag says they are good.
        if (crc_load) begin
            st_nxt.crc_high = crc_value[15:8];
            st_nxt.crc_low = crc_value[7:0];
        end
        st_nxt.bit_div = bit_tick ? BIT_LAST : st_r.bit_div - 8'h01;
        // A new end of transmission restarts the wait window; the bit
        // divider is shared, so the first bit period may be short.
        if (tx_done) begin
            st_nxt.waiting = 1'b1;
            st_nxt.wait_cnt = {2'b00, st_r.tx_wait} + rf_cfg_pkg::RESP_WAIT_BASE;
        end else if (st_r.waiting && bit_tick) begin
            if (st_r.wait_cnt == 4'h1) begin
                st_nxt.waiting = 1'b0;
                st_nxt.wait_done = 1'b1;
            end
            st_nxt.wait_cnt = st_r.wait_cnt - 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.tx_wait <= rf_cfg_pkg::RST_TX_PARAM[1:0];
            st_r.par_off <= rf_cfg_pkg::RST_RX_PARAM[4];
            st_r.speed <= rf_cfg_pkg::RST_UART_SPEED;
            st_r.crc_high <= rf_cfg_pkg::RST_CRC_BYTE;
            st_r.crc_low <= rf_cfg_pkg::RST_CRC_BYTE;
            st_r.mod_width <= rf_cfg_pkg::RST_MOD_WIDTH;
            st_r.bit_div <= BIT_LAST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign reg_rdata = st_r.rdata;
    assign added_response_wait = st_r.tx_wait;
    assign response_wait_busy = st_r.waiting;
    assign response_wait_done = st_r.wait_done;
    assign tx_parity_gen = !st_r.par_off;
    assign rx_parity_check = !st_r.par_off;
    assign rx_parity_as_data = st_r.par_off;
    assign baud_coarse_factor =
        st_r.speed[rf_cfg_pkg::COARSE_LSB +: rf_cfg_pkg::COARSE_W];
    assign baud_fine_factor =
        st_r.speed[rf_cfg_pkg::FINE_LSB +: rf_cfg_pkg::FINE_W];

    // ---------------------------------------------------------------
    // Modulation pulse
    // ---------------------------------------------------------------
    // Software must keep the width under half a bit period; the pulse
    // generator does not clip it.
    mod_pulse_if mp ();

    assign mp.width = st_r.mod_width;
    assign mp.start = mod_start;
    assign mod_pulse = mp.pulse;

    miller_pulse_gen #(
        .CARRIER_DIV(CARRIER_DIV)
    ) u_pulse (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .mp(mp)
    );

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    AST_ADDED_RESPONSE_WAIT_WR: assert property (
        reg_wr && reg_addr == rf_cfg_pkg::OFS_TX_PARAM
        |=> added_response_wait == $past(reg_wdata[1:0]))
        else $error("Response wait field did not take the write");

    AST_WAIT_LEN: assert property (
        tx_done |=> st_r.wait_cnt == {2'b00, added_response_wait} + 4'h7 && st_r.waiting)
        else $error("Response wait not loaded with field plus seven");

    AST_PAR_OFF: assert property (
        reg_wr && reg_addr == rf_cfg_pkg::OFS_RX_PARAM && reg_wdata[4]
        |=> !tx_parity_gen && !rx_parity_check)
        else $error("Parity still active after parity off");

    AST_PAR_DATA: assert property (
        reg_wr && reg_addr == rf_cfg_pkg::OFS_RX_PARAM
        |=> rx_parity_as_data == $past(reg_wdata[4]) && rx_parity_as_data == !rx_parity_check)
        else $error("Parity bit handling did not follow parity off");

    AST_RSVD_RD: assert property (
        reg_rd && reg_addr == rf_cfg_pkg::OFS_RSVD_23 |=> reg_rdata == 8'h88)
        else $error("Reserved_23 read wrong value");

    AST_COARSE: assert property (
        reg_wr && reg_addr == rf_cfg_pkg::OFS_UART_SPEED
        |=> baud_coarse_factor == $past(reg_wdata[7:5]))
        else $error("Coarse factor did not take the write");

    AST_FINE: assert property (
        reg_wr && reg_addr == rf_cfg_pkg::OFS_UART_SPEED
        |=> baud_fine_factor == $past(reg_wdata[4:0]))
        else $error("Fine factor did not take the write");

    AST_RESET_VAL: assert property (disable iff (1'b0)
        !rst_n |=> baud_coarse_factor == 3'h7 && baud_fine_factor == 5'h0B)
        else $error("Speed register not EBh after reset");

    AST_CRC_RD: assert property (
        reg_rd && reg_addr == rf_cfg_pkg::OFS_CRC_LOW && !crc_load
        |=> reg_rdata == $past(st_r.crc_low))
        else $error("CRC low byte read wrong value");

    AST_CRC_RESET: assert property (disable iff (1'b0)
        !rst_n |=> {st_r.crc_high, st_r.crc_low} == 16'hFFFF)
        else $error("CRC result not FFFFh after reset");

    AST_CRC_HOLD: assert property (
        !crc_load |=> $stable({st_r.crc_high, st_r.crc_low}))
        else $error("CRC result changed without a completed calculation");

    AST_RSVD_WR: assert property (
        reg_rd && reg_addr == rf_cfg_pkg::OFS_RX_PARAM |=> (reg_rdata & 8'hEF) == 8'h00)
        else $error("Reserved receive bits took a write");

    AST_WAIT_DONE: assert property (
        response_wait_done
        |-> !response_wait_busy && $past(response_wait_busy))
        else $error("Response wait ended without a running window");

    AST_WAIT_TICK: assert property (
        response_wait_busy && !bit_tick && !tx_done
        |=> $stable(st_r.wait_cnt))
        else $error("Response wait counted off a bit period boundary");

    AST_CRC_LOAD: assert property (
        crc_load
        |=> {st_r.crc_high, st_r.crc_low} == $past(crc_value))
        else $error("CRC result did not take the completed value");

    AST_CRC_HIGH_RD: assert property (
        reg_rd && reg_addr == rf_cfg_pkg::OFS_CRC_HIGH
        |=> reg_rdata == $past(st_r.crc_high))
        else $error("CRC high byte read wrong value");

    AST_RSVD_1E_RD: assert property (
        reg_rd && reg_addr == rf_cfg_pkg::OFS_RSVD_1E
        |=> reg_rdata == rf_cfg_pkg::RST_RSVD_1E)
        else $error("Reserved_1e read wrong value");

    AST_RSVD_20_RD: assert property (
        reg_rd && reg_addr == rf_cfg_pkg::OFS_RSVD_20
        |=> reg_rdata == rf_cfg_pkg::RST_RSVD_20)
        else $error("Reserved_20 read wrong value");

    AST_RSVD_25_RD: assert property (
        reg_rd && reg_addr == rf_cfg_pkg::OFS_RSVD_25
        |=> reg_rdata == rf_cfg_pkg::RST_RSVD_25)
        else $error("Reserved_25 read wrong value");

    AST_TX_RSVD_RD: assert property (
        reg_rd && reg_addr == rf_cfg_pkg::OFS_TX_PARAM
        |=> reg_rdata[7:2] == rf_cfg_pkg::RST_TX_PARAM[7:2])
        else $error("Reserved transmit bits read wrong value");

    AST_WIDTH_WR: assert property (
        reg_wr && reg_addr == rf_cfg_pkg::OFS_MOD_WIDTH
        |=> mp.width == $past(reg_wdata))
        else $error("Modulation width did not take the write");

    AST_PULSE_START: assert property (
        mod_start && !mod_pulse
        |=> mod_pulse)
        else $error("Modulation pulse did not start");

    AST_SPEED_KEEP: assert property (
        !(reg_wr && reg_addr == rf_cfg_pkg::OFS_UART_SPEED)
        |=> $stable({baud_coarse_factor, baud_fine_factor}))
        else $error("Speed factors changed without a write");
endmodule

// File: sim/rf_front_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// RF side stand-in: transmitter, CRC engine and modulation trigger
// ----------------------------------------------------------------
module rf_front_model (
    input wire logic ref_clk,
    output logic tx_done,
    output logic crc_load,
    output logic [15:0] crc_value,
    output logic mod_start
);
    initial begin
        tx_done = 1'b0;
        crc_load = 1'b0;
        crc_value = 16'h0000;
        mod_start = 1'b0;
    end

    task automatic end_frame();
        @(posedge ref_clk);
        tx_done <= 1'b1;
        @(posedge ref_clk);
        tx_done <= 1'b0;
    endtask

    task automatic finish_crc(input logic [15:0] v);
        @(posedge ref_clk);
        crc_load <= 1'b1;
        crc_value <= v;
        @(posedge ref_clk);
        crc_load <= 1'b0;
        // The result bus is not held after the load, so a late capture shows up.
        crc_value <= ~v;
    endtask

    task automatic trigger_mod();
        @(posedge ref_clk);
        mod_start <= 1'b1;
        @(posedge ref_clk);
        mod_start <= 1'b0;
    endtask
endmodule

// File: sim/rf_protocol_config_regs_test.sv
`timescale 1ns/1ps
module rf_protocol_config_regs_test;
    localparam int BD = 16;
    localparam logic [5:0] ADDRS [11] = '{6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h22,
        6'h23, 6'h24, 6'h25, 6'h3F};
    localparam logic [7:0] RSTV [11] = '{8'h62, 8'h00, 8'h00, 8'hEB, 8'h00, 8'hFF, 8'hFF,
        8'h88, 8'h26, 8'h87, 8'h00};
    logic ref_clk, rst_n, reg_wr, reg_rd;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic tx_done, crc_load, mod_start, mod_pulse, response_wait_busy, response_wait_done;
    logic [15:0] crc_value;
    logic [1:0] added_response_wait;
    logic tx_parity_gen, rx_parity_check, rx_parity_as_data;
    logic [2:0] baud_coarse_factor;
    logic [4:0] baud_fine_factor;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [15:0] mod_cnt = 16'h0000;

    rf_protocol_config_regs #(.BIT_DIV(BD), .CARRIER_DIV(1)) i_rf_protocol_config_regs (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_done(tx_done),
        .response_wait_busy(response_wait_busy), .response_wait_done(response_wait_done),
        .added_response_wait(added_response_wait), .tx_parity_gen(tx_parity_gen),
        .rx_parity_check(rx_parity_check), .rx_parity_as_data(rx_parity_as_data),
        .baud_coarse_factor(baud_coarse_factor), .baud_fine_factor(baud_fine_factor),
        .crc_load(crc_load), .crc_value(crc_value), .mod_start(mod_start),
        .mod_pulse(mod_pulse));

    rf_front_model i_rf_front_model (.ref_clk(ref_clk), .tx_done(tx_done),
        .crc_load(crc_load), .crc_value(crc_value), .mod_start(mod_start));

    // ----------------------------------------------------------------
    // Clock, timeout and pulse counter
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (mod_pulse === 1'b1) mod_cnt <= mod_cnt + 16'h0001;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Readback after a write of d, before any CRC load has happened.
    function automatic logic [7:0] expv(input logic [5:0] a, input logic [7:0] d);
        case (a)
            6'h1C: return {6'h18, d[1:0]};
            6'h1D: return {3'h0, d[4], 4'h0};
            6'h1F, 6'h24: return d;
            6'h21, 6'h22: return 8'hFF;
            6'h23: return 8'h88;
            6'h25: return 8'h87;
            default: return 8'h00;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values();
        logic [7:0] d;
        check(added_response_wait, 2'h2);
        check(tx_parity_gen, 1'h1);
        check(rx_parity_as_data, 1'h0);
        check({baud_coarse_factor, baud_fine_factor}, 8'hEB);
        for (int i = 0; i < 11; i++) begin
            rd(ADDRS[i], d);
            check(d, RSTV[i]);
        end
    endtask

    task automatic t_write_all(input logic [7:0] p);
        logic [7:0] d;
        for (int i = 0; i < 11; i++) wr(ADDRS[i], p);
        for (int i = 0; i < 11; i++) begin
            rd(ADDRS[i], d);
            check(d, expv(ADDRS[i], p));
        end
        check(added_response_wait, p[1:0]);
        check(tx_parity_gen, !p[4]);
        check(rx_parity_check, !p[4]);
        check(rx_parity_as_data, p[4]);
        check(baud_coarse_factor, p[7:5]);
        check(baud_fine_factor, p[4:0]);
    endtask

    task automatic t_speed_back_to_back();
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= 6'h1F;
        reg_wdata <= 8'hA5;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        #1 check({baud_coarse_factor, baud_fine_factor}, 8'hA5);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, 8'hA5);
        @(posedge ref_clk);
        #1 check(reg_rdata, 8'h00);
    endtask

    task automatic t_crc(input logic [15:0] v);
        logic [7:0] d;
        i_rf_front_model.finish_crc(v);
        wr(6'h21, ~v[15:8]);
        wr(6'h22, ~v[7:0]);
        rd(6'h21, d);
        check(d, v[15:8]);
        rd(6'h22, d);
        check(d, v[7:0]);
    endtask

    task automatic t_response_wait(input logic [1:0] w);
        int cnt;
        int n;
        cnt = 0;
        n = int'(w) + 7;
        wr(6'h1C, {6'h00, w});
        i_rf_front_model.end_frame();
        #1 check(response_wait_busy, 1'h1);
        do begin
            @(posedge ref_clk);
            #1 cnt++;
        end while (response_wait_done !== 1'b1 && cnt < 400);
        check(response_wait_busy, 1'h0);
        check(cnt >= (n - 1) * BD + 1 && cnt <= n * BD + 1, 1'h1);
    endtask

    task automatic t_mod_pulse(input logic [7:0] w);
        logic [15:0] base;
        wr(6'h24, w);
        #1 base = mod_cnt;
        i_rf_front_model.trigger_mod();
        // The second start comes two cycles after the first: a longer pulse
        // ignores it, while a one-cycle pulse has ended and a new one runs.
        i_rf_front_model.trigger_mod();
        repeat (12) @(posedge ref_clk);
        #1 check(mod_cnt - base, (w == 8'h00) ? 16'h0002 : {8'h00, w} + 16'h0001);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_write_all(8'hFF);
        t_write_all(8'h00);
        t_speed_back_to_back();
        t_crc(16'h1234);
        t_crc(16'hC35A);
        for (int w = 0; w < 4; w++) t_response_wait(w[1:0]);
        // Widths stay within half of a sixteen-cycle bit period.
        t_mod_pulse(8'h00);
        t_mod_pulse(8'h03);
        t_mod_pulse(8'h07);
        wrap_up();
    end
endmodule
